// ### mfkm_masker.sv
// mfkm_masker: applies one key stream segment to a serial full-slot field.
// assumes the framing logic feeds field bits a0 first on clk_sys and that
// the key stream generator streams its output bits with valid/ready.
//
// Function
// (RULE_01) field is 64 A bits plus 324 B bits
// (RULE_02) A-field: header, 40-bit tail, 16-bit crc
// (RULE_03) tail type taken from header code
// (RULE_04) B-field: 320 data bits, 4 parity bits
// (RULE_05) unprotected format: all 320 bits payload
// (RULE_06) multisubfield: four 64-bit payloads plus crcs
// (RULE_07) mixed control-user field handled as control
// (RULE_08) singlesubfield: 304 payload bits, one crc
// (RULE_09) user format follows negotiated service type
// (RULE_10) header and crc clear; control tail encrypted
// (RULE_11) parity, subfield crcs, codec redundancy never encrypted
// (RULE_12) control field: every subfield payload encrypted
// (RULE_13) key stream of twice 360 bits
// (RULE_14) segment equals tail plus B data bits
// (RULE_15) two segments in generation order, index 0 first
// (RULE_16) control tail: segment 0..39 onto a8..a47
// (RULE_17) other tail: segment 0..39 discarded
// (RULE_18) unprotected: segment 40..359 onto b0..b319
// (RULE_19) singlesubfield: segment 40..343 onto b0..b303
// (RULE_20) multisubfield: four 64-bit runs, gaps unused
// (RULE_21) encoded: segment 40 up to 320r+39
// (RULE_22) decryption uses identical mapping
// (RULE_23) crcs computed and checked over encrypted bits
// (RULE_24) segment order depends on side and direction
// (RULE_25) generator re-initialised every encrypted frame
// (RULE_26) clear mode: pass through, no key use
`timescale 1ns/100ps
module mfkm_masker
    import mfkm_pkg::*;
(
    input wire logic clk_sys, // 50 MHz system clock
    input wire logic nrst, // async reset, active low
    input wire logic hsel, // ahb slave select
    input wire logic [7:0] haddr, // ahb byte address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response, always okay
    output logic [31:0] hrdata, // ahb read data
    input wire logic frame_start, // frame strobe from framing logic
    output logic ksg_init, // re-init pulse to key generator
    input wire logic ks_valid, // key stream bit valid
    input wire logic ks_bit, // key stream bit
    output logic ks_ready, // key stream bit accepted
    input wire logic fld_valid, // field bit valid
    input wire mfkm_fbit_t fld_in, // field bit with framing
    output logic fld_ready, // field bit can be taken
    output logic out_valid, // masked bit valid
    output mfkm_fbit_t fld_out // masked bit with framing
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_READY
    } mfkm_state_t;

    mfkm_state_t state;
    logic enc_en;
    logic side_portable;
    mfkm_svc_t user_svc;
    logic [2:0] ctl_tail_code;
    logic [2:0] user_ba_code;
    logic [8:0] enc_len;
    logic frame_enc;
    logic [PAIR_BITS-1:0] seg_pair;
    logic [9:0] ks_cnt;
    logic [8:0] pos;
    logic use_second;
    logic ctl_tail;
    logic [1:0] b_fmt;
    logic [7:0] hdr;
    logic [7:0] field_cnt;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_ok;
    logic [8:0] cur_pos;
    logic cur_dir;
    logic cur_use_second;
    logic cur_ctl_tail;
    logic [1:0] cur_fmt;
    logic [7:0] cur_hdr;
    logic key_hit;
    logic [9:0] key_idx;
    logic ks_take;
    logic fld_take;

    // B-field data bit b is payload to be masked under format fmt
    function automatic logic b_payload(input logic [8:0] b, input logic [1:0] fmt,
                                       input logic [8:0] elen);
        logic [8:0] sub_off;
        sub_off = b % 9'(SUB_BITS);
        case (fmt)
            SVC_UNPROT: b_payload = (b < 9'(B_DATA_BITS)); // [RULE_05] [RULE_18]
            SVC_MULTI: b_payload = (b < 9'(B_DATA_BITS)) &&
                                   (sub_off < 9'(SUB_PAY_BITS)); // [RULE_06] [RULE_20]
            SVC_SINGLE: b_payload = (b < 9'(SINGLE_PAY_BITS)); // [RULE_08] [RULE_19]
            SVC_ENCODED: b_payload = (b < elen); // [RULE_21]
            default: b_payload = 1'b0;
        endcase
    endfunction

    // segment bit index of a field position; the a-field crc carries no key
    // bits, so b-field data continue the segment right after the tail
    function automatic logic [9:0] seg_index(input logic [8:0] p, input logic second);
        logic [8:0] off;
        if (p >= B_FIRST)
            off = p - B_FIRST + 9'(TAIL_BITS);
        else
            off = p - TAIL_FIRST;
        seg_index = 10'(off) + (second ? SEG_SECOND : 10'h000);
    endfunction

    // address phase qualifier
    assign addr_ok = hsel && hready && htrans[1];

    // one key bit or one field bit changes hands at this edge
    assign ks_take = ks_valid && ks_ready;
    assign fld_take = fld_valid && fld_ready;

    // ahb handshake: zero wait state, always okay
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ahb write address capture for the data phase
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr;
        end
    end

    // control registers written in the data phase
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            enc_en <= 1'b0;
            side_portable <= 1'b0;
            user_svc <= SVC_UNPROT;
            ctl_tail_code <= CTL_TAIL_RST;
            user_ba_code <= USER_BA_RST;
            enc_len <= ENC_LEN_RST;
        end
        else if (wr_pend)
        begin
            case (wr_addr)
                REG_CTRL:
                begin
                    enc_en <= hwdata[CTRL_ENC];
                    side_portable <= hwdata[CTRL_SIDE];
                    user_svc <= mfkm_svc_t'(hwdata[CTRL_SVC_LSB +: 2]);
                    ctl_tail_code <= hwdata[CTRL_TCODE_LSB +: CODE_W];
                    user_ba_code <= hwdata[CTRL_UCODE_LSB +: CODE_W];
                end
                REG_ENC_LEN:
                begin
                    // payload may never run past the last segment bit
                    if (hwdata[8:0] > ENC_LEN_MAX)
                        enc_len <= ENC_LEN_MAX;
                    else
                        enc_len <= hwdata[8:0];
                end
                default:
                begin
                end
            endcase
        end
    end

    // ahb read data, registered at the address phase
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
        begin
            case (haddr)
                REG_CTRL: hrdata <= {22'h000000, user_ba_code, ctl_tail_code,
                                     user_svc, side_portable, enc_en};
                REG_ENC_LEN: hrdata <= {23'h000000, enc_len};
                REG_STATUS: hrdata <= {16'h0000, field_cnt, 4'h0,
                                       frame_enc, state == ST_LOAD,
                                       state == ST_READY, 1'b0};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // frame sequencing and key stream loading
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ST_IDLE;
            frame_enc <= 1'b0;
            ksg_init <= 1'b0;
            ks_ready <= 1'b0;
            ks_cnt <= 10'h000;
        end
        else
        begin
            ksg_init <= 1'b0;
            if (frame_start)
            begin
                frame_enc <= enc_en;
                ks_cnt <= 10'h000;
                if (enc_en)
                begin
                    ksg_init <= 1'b1; // [RULE_25]
                    ks_ready <= 1'b1; // [RULE_13]
                    state <= ST_LOAD;
                end
                else
                begin
                    ks_ready <= 1'b0; // [RULE_26]
                    state <= ST_READY;
                end
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        // waits for the first frame strobe
                    end
                    ST_LOAD:
                    begin
                        if (ks_take)
                        begin
                            ks_cnt <= ks_cnt + 10'h001;
                            if (ks_cnt == KS_LAST)
                            begin
                                ks_ready <= 1'b0;
                                state <= ST_READY;
                            end
                        end
                    end
                    ST_READY:
                    begin
                        // key pair held until the next frame strobe
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // segment pair storage, index 0 is the earliest generator bit
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            seg_pair <= '0;
        else if (state == ST_LOAD && ks_take && !frame_start)
            seg_pair[ks_cnt] <= ks_bit; // [RULE_15]
    end

    // field bits are stalled while the key pair is still loading
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            fld_ready <= 1'b0;
        else
            fld_ready <= (state == ST_READY) && !frame_start;
    end

    // position and per-field context of the incoming bit
    always_comb
    begin
        cur_pos = fld_in.first ? 9'h000 : pos;
        cur_dir = fld_in.first ? fld_in.dir : 1'b0;
        cur_use_second = fld_in.first ? (side_portable ^ fld_in.dir) : use_second; // [RULE_24]
        cur_hdr = hdr;
        if (cur_pos < TAIL_FIRST)
            cur_hdr[cur_pos[2:0]] = fld_in.data;
        cur_ctl_tail = (cur_hdr[HDR_TAIL_LSB +: CODE_W] == ctl_tail_code); // [RULE_03]
        // content code picks control layout or the negotiated user layout
        if (cur_hdr[HDR_BA_LSB +: CODE_W] == user_ba_code)
            cur_fmt = user_svc; // [RULE_09]
        else
            cur_fmt = SVC_MULTI; // [RULE_07] [RULE_12]
        if (cur_pos >= TAIL_FIRST)
        begin
            cur_ctl_tail = ctl_tail;
            cur_fmt = b_fmt;
        end
    end

    // key bit selection and the segment index of the current bit
    always_comb
    begin
        key_hit = 1'b0;
        if (cur_pos >= TAIL_FIRST && cur_pos < TAIL_END)
            key_hit = cur_ctl_tail; // [RULE_10] [RULE_16] [RULE_17]
        else if (cur_pos >= B_FIRST)
            key_hit = b_payload(cur_pos - B_FIRST, cur_fmt, enc_len); // [RULE_04] [RULE_11]
        key_idx = seg_index(cur_pos, cur_use_second); // [RULE_14]
        // never index past the stored pair
        if (key_idx > KS_LAST)
            key_hit = 1'b0;
    end

    // per-field context capture
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pos <= 9'h000;
            use_second <= 1'b0;
            ctl_tail <= 1'b0;
            b_fmt <= SVC_UNPROT;
            hdr <= 8'h00;
            field_cnt <= 8'h00;
        end
        else if (fld_take)
        begin
            hdr <= cur_hdr;
            use_second <= cur_use_second;
            ctl_tail <= cur_ctl_tail;
            b_fmt <= cur_fmt;
            if (cur_pos == POS_LAST)
            begin
                pos <= 9'h000; // [RULE_01]
                field_cnt <= field_cnt + 8'h01;
            end
            else
                pos <= cur_pos + 9'h001;
        end
    end

    // masked output; the same mapping serves both directions, and crcs are
    // generated and checked downstream over the masked bits
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            out_valid <= 1'b0;
            fld_out <= '0;
        end
        else
        begin
            out_valid <= fld_take; // [RULE_23]
            fld_out.first <= fld_in.first;
            fld_out.dir <= fld_in.first ? cur_dir : fld_in.dir;
            fld_out.data <= fld_in.data ^ (frame_enc && key_hit && seg_pair[key_idx]); // [RULE_22] [RULE_26] [RULE_02]
        end
    end
endmodule

// ### mfkm_pkg.sv
// mfkm_pkg: constants and carrier types for the mac field key stream masker.
// assumes one 50 MHz system clock and an AHB-Lite register port.
package mfkm_pkg;
    // field geometry of one full-slot two-level field
    localparam int FIELD_BITS = 388;
    localparam int A_BITS = 64;
    localparam int B_BITS = 324;
    localparam int HDR_BITS = 8;
    localparam int TAIL_BITS = 40;
    localparam int ACRC_BITS = 16;
    localparam int B_DATA_BITS = 320;
    localparam int B_PAR_BITS = 4;
    localparam int SUB_PAY_BITS = 64;
    localparam int SUB_CRC_BITS = 16;
    localparam int SUB_BITS = SUB_PAY_BITS + SUB_CRC_BITS;
    localparam int SINGLE_PAY_BITS = 304;
    // key stream segment geometry
    localparam int SEG_BITS = TAIL_BITS + B_BITS - B_PAR_BITS;
    localparam int PAIR_BITS = 2 * SEG_BITS;
    localparam logic [8:0] TAIL_FIRST = 9'(HDR_BITS);
    localparam logic [8:0] TAIL_END = 9'(HDR_BITS + TAIL_BITS);
    localparam logic [8:0] B_FIRST = 9'(A_BITS);
    localparam logic [8:0] POS_LAST = 9'(FIELD_BITS - 1);
    localparam logic [9:0] KS_LAST = 10'(PAIR_BITS - 1);
    localparam logic [9:0] SEG_SECOND = 10'(SEG_BITS);
    // header sub-fields: tail code in bits 1..3, b-field content code in 4..6
    localparam int HDR_TAIL_LSB = 1;
    localparam int HDR_BA_LSB = 4;
    localparam int CODE_W = 3;
    // register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ENC_LEN = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    // control register fields
    localparam int CTRL_ENC = 0;
    localparam int CTRL_SIDE = 1;
    localparam int CTRL_SVC_LSB = 2;
    localparam int CTRL_TCODE_LSB = 4;
    localparam int CTRL_UCODE_LSB = 7;
    localparam logic [2:0] CTL_TAIL_RST = 3'h6;
    localparam logic [2:0] USER_BA_RST = 3'h0;
    localparam logic [8:0] ENC_LEN_RST = 9'h140;
    localparam logic [8:0] ENC_LEN_MAX = 9'(B_DATA_BITS);
    // user service selection
    typedef enum logic [1:0] {
        SVC_UNPROT = 2'h0,
        SVC_MULTI = 2'h1,
        SVC_SINGLE = 2'h2,
        SVC_ENCODED = 2'h3
    } mfkm_svc_t;
    // one serial field bit with its framing
    typedef struct packed {
        logic first;
        logic dir;
        logic data;
    } mfkm_fbit_t;
endpackage

// ### mfkm_placeholder_none.sv
`timescale 1ns/100ps

// ### mfkm_keygen.sv
// mfkm_keygen: behavioural key stream generator on the masker key port.
// assumes restart by ksg_init and a frame number from the framing side.
`timescale 1ns/100ps
module mfkm_keygen (
    input wire logic clk_sys, // clock
    input wire logic nrst, // reset, low
    input wire logic slow, // gaps between bits
    input wire logic [3:0] frame_no, // init value
    input wire logic ksg_init, // restart pulse
    input wire logic ks_ready, // bit taken
    output logic ks_valid, // bit offered
    output logic ks_bit // key bit
);
    logic [9:0] idx;
    logic [9:0] cur;
    logic [1:0] gap;
    logic last;
    function automatic logic kf(input logic [11:0] n);
        return ^(n & 12'hB5D) ^ (n[1] & n[4]);
    endfunction
    // restart at bit 0, stream differs per frame number
    assign cur = ksg_init ? 10'h000 : idx;
    assign ks_bit = ks_valid ? kf(12'(cur) + 12'(3 * frame_no)) : ~last;
    // bits advance in generation order, valid held until taken
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            idx <= 10'h000;
            gap <= 2'h0;
            ks_valid <= 1'b0;
            last <= 1'b0;
        end
        else
        begin
            gap <= gap + 2'h1;
            idx <= (ks_valid && ks_ready) ? cur + 10'h001 : cur;
            if (ks_valid && ks_ready)
                last <= ks_bit;
            ks_valid <= (ks_valid && !ks_ready) || !slow || gap == 2'h3;
        end
    end
endmodule

// ### mfkm_masker_props.sv
// mfkm_masker_props: port timing and clear-bit checks on the masker.
// assumes the bind at the foot attaches it to every masker instance.
`timescale 1ns/100ps
module mfkm_masker_props
    import mfkm_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic nrst, // reset, low
    input wire logic frame_start, // frame strobe
    input wire logic ksg_init, // key restart
    input wire logic ks_valid, // key valid
    input wire logic ks_ready, // key taken
    input wire logic fld_valid, // field valid
    input wire mfkm_fbit_t fld_in, // field in
    input wire logic fld_ready, // field ready
    input wire logic out_valid, // masked valid
    input wire mfkm_fbit_t fld_out // masked out
);
    logic [9:0] kcnt;
    logic [8:0] pos;
    logic keyed;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // key bits since restart, field position, key use in this frame
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            kcnt <= 10'h000;
            pos <= 9'h000;
            keyed <= 1'b0;
        end
        else
        begin
            kcnt <= (ksg_init ? 10'h000 : kcnt) + 10'(ks_valid && ks_ready);
            if (fld_valid && fld_ready)
                pos <= fld_in.first ? 9'h000 : pos + 9'h001;
            keyed <= frame_start ? 1'b0 : (keyed || ksg_init);
        end
    end
    sequence enc_start_s;
        frame_start ##1 ksg_init;
    endsequence
    sequence clr_start_s;
        frame_start ##1 !ksg_init;
    endsequence
    init_cause_a: assert property (ksg_init |-> $past(frame_start))
        else $error("restart without frame strobe");
    load_open_a: assert property (enc_start_s |-> ks_ready && !fld_ready)
        else $error("key load not opened");
    clear_nokey_a: assert property (clr_start_s |-> !ks_ready [*3])
        else $error("key taken in clear frame");
    load_rise_a: assert property ($rose(ks_ready) |-> ksg_init)
        else $error("load without restart");
    load_count_a: assert property ($fell(ks_ready) |-> kcnt == 10'h2D0)
        else $error("key pair length wrong");
    load_stall_a: assert property (ks_ready && !ksg_init |-> !fld_ready && kcnt < 10'h2D0)
        else $error("field open during load");
    out_lat_a: assert property (fld_valid && fld_ready |=> out_valid
        && fld_out.first == $past(fld_in.first) && fld_out.dir == $past(fld_in.dir))
        else $error("output latency or framing wrong");
    hdr_clear_a: assert property (out_valid && (pos < 9'h008 || pos >= 9'h030 && pos < 9'h040)
        |-> fld_out.data == $past(fld_in.data)) else $error("header or crc altered");
    par_clear_a: assert property (out_valid && pos >= 9'h180
        |-> fld_out.data == $past(fld_in.data)) else $error("parity altered");
    clear_pass_a: assert property (out_valid && !keyed
        |-> fld_out.data == $past(fld_in.data)) else $error("clear frame altered");
endmodule
bind mfkm_masker mfkm_masker_props u_props (.clk_sys(clk_sys), .nrst(nrst),
    .frame_start(frame_start), .ksg_init(ksg_init), .ks_valid(ks_valid), .ks_ready(ks_ready),
    .fld_valid(fld_valid), .fld_in(fld_in), .fld_ready(fld_ready), .out_valid(out_valid),
    .fld_out(fld_out));

// ### mfkm_masker_tb.sv
// mfkm_masker_tb: registers, key mapping per format and clear mode.
// assumes the keygen model on the key port and the bench as framing side.
`timescale 1ns/100ps
module mfkm_masker_tb
    import mfkm_pkg::*;
;
    logic clk_sys, nrst, hsel, hwrite, frame_start, fld_valid, slow;
    logic hready, hreadyout, hresp, ksg_init, ks_valid, ks_bit, ks_ready, fld_ready, out_valid;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [3:0] frame_no;
    mfkm_fbit_t fld_in, fld_out;
    logic [387:0] e;
    int oidx, n_mismatch, checks_done, nfld;
    assign hready = hreadyout;
    mfkm_masker u_dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_start(frame_start),
        .ksg_init(ksg_init), .ks_valid(ks_valid), .ks_bit(ks_bit), .ks_ready(ks_ready),
        .fld_valid(fld_valid), .fld_in(fld_in), .fld_ready(fld_ready), .out_valid(out_valid),
        .fld_out(fld_out));
    mfkm_keygen u_ksg (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .frame_no(frame_no),
        .ksg_init(ksg_init), .ks_ready(ks_ready), .ks_valid(ks_valid), .ks_bit(ks_bit));
    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;
    function automatic logic kf(input int k);
        logic [11:0] n;
        n = 12'(k + 3 * int'(frame_no));
        return ^(n & 12'hB5D) ^ (n[1] & n[4]);
    endfunction
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        checks_done++;
        if (ex !== sn)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, ex, sn);
        end
    endtask
    // single ahb transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge clk_sys);
        while (hready !== 1'b1)
            @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hready !== 1'b1)
            @(posedge clk_sys);
        r = hrdata;
    endtask
    // compare masked bits as they appear
    always @(negedge clk_sys)
    begin
        if (out_valid === 1'b1)
        begin
            chk("masked bit", 32'(e[oidx]), 32'(fld_out.data));
            oidx++;
        end
    end
    task automatic run_frame(input logic en, sd, dr, input logic [1:0] sv,
        input logic [2:0] tc, bc, input logic [8:0] el, input logic sl);
        logic [31:0] r;
        logic [387:0] f;
        logic pay;
        int p;
        int b;
        frame_no <= frame_no + 4'h1;
        slow <= sl;
        ahb(1'b1, REG_CTRL, 32'({3'h0, CTL_TAIL_RST, sv, sd, en}), r);
        ahb(1'b1, REG_ENC_LEN, 32'(el), r);
        ahb(1'b0, REG_CTRL, 32'h0, r);
        chk("ctrl", 32'({3'h0, CTL_TAIL_RST, sv, sd, en}), r);
        for (p = 0; p < 388; p++)
        begin
            b = p - 64;
            f[p] = (p % 3 == 0) ^ (p % 7 == 1);
            pay = (bc != USER_BA_RST || sv == SVC_MULTI) ? (b % 80 < 64) : (sv == SVC_SINGLE
                ? b < 304 : (sv == SVC_ENCODED ? b < int'(el) : 1'b1));
            if (p < 8)
                f[p] = p inside {[1:3]} ? tc[(p - 1) % 3] : (p inside {[4:6]} ? bc[p - 4] : 1'b0);
            e[p] = f[p];
            if (en && p >= 8 && p < 48 && tc == CTL_TAIL_RST)
                e[p] = f[p] ^ kf(((sd ^ dr) ? 360 : 0) + p - 8);
            else if (en && p >= 64 && p < 384 && pay)
                e[p] = f[p] ^ kf(((sd ^ dr) ? 360 : 0) + b + 40);
        end
        oidx = 0;
        frame_start <= 1'b1;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        @(posedge clk_sys);
        while (fld_ready !== 1'b1)
            @(posedge clk_sys);
        fld_valid <= 1'b1;
        for (p = 0; p < 388; p++)
        begin
            fld_in <= {p == 0, dr, f[p]};
            @(posedge clk_sys);
            while (fld_ready !== 1'b1)
                @(posedge clk_sys);
        end
        fld_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("bits out", 32'h184, 32'(oidx));
        ahb(1'b0, REG_STATUS, 32'h0, r);
        chk("status enc", 32'(en), 32'(r[3]));
        nfld++;
        chk("field count", 32'(nfld), 32'(r[15:8]));
        chk("status ready", 32'h1, 32'(r[1]));
    endtask
    task automatic t_regs();
        logic [31:0] r;
        ahb(1'b0, REG_CTRL, 32'h0, r);
        chk("ctrl reset", {22'h0, USER_BA_RST, CTL_TAIL_RST, 4'h0}, r);
        ahb(1'b0, REG_ENC_LEN, 32'h0, r);
        chk("enc_len reset", 32'(ENC_LEN_RST), r);
        ahb(1'b1, REG_ENC_LEN, 32'h000001FF, r);
        ahb(1'b0, REG_ENC_LEN, 32'h0, r);
        chk("enc_len clamp", 32'(ENC_LEN_MAX), r);
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF, r);
        ahb(1'b0, 8'h0C, 32'h0, r);
        chk("unmapped", 32'h0, r);
    endtask
    task automatic t_maps();
        run_frame(1'h1, 1'h0, 1'h0, SVC_UNPROT, 3'h6, 3'h0, 9'h140, 1'h0);
        run_frame(1'h1, 1'h0, 1'h1, SVC_MULTI, 3'h2, 3'h0, 9'h140, 1'h0);
        run_frame(1'h1, 1'h1, 1'h0, SVC_SINGLE, 3'h6, 3'h0, 9'h140, 1'h1);
        run_frame(1'h1, 1'h1, 1'h1, SVC_ENCODED, 3'h6, 3'h0, 9'h0A0, 1'h0);
        run_frame(1'h1, 1'h0, 1'h0, SVC_SINGLE, 3'h6, 3'h5, 9'h140, 1'h0);
    endtask
    task automatic t_clear();
        run_frame(1'h0, 1'h0, 1'h0, SVC_UNPROT, 3'h6, 3'h0, 9'h140, 1'h0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // reset for two cycles, then the scenarios
    initial
    begin
        {clk_sys, nrst, hsel, hwrite, frame_start, fld_valid, slow} = 7'h00;
        {haddr, htrans, hsize, hwdata, frame_no} = {8'h00, 2'h0, 3'h2, 32'h0, 4'h0};
        fld_in = 3'h0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        t_regs();
        t_maps();
        t_clear();
        give_verdict();
    end
    // hang guard, well past six frames with one slow key load
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        n_mismatch++;
        give_verdict();
    end
endmodule
